/* rtl/cycle_steal_defines.svh */
// Constants for the cycle-stealing block transfer controller
// Assumes a 12-bit backplane bus with twelve priority lines
`ifndef CYCLE_STEAL_DEFINES_SVH
`define CYCLE_STEAL_DEFINES_SVH
`define CS_WORD_WIDTH 12
`define CS_PRIO_LINES 12
`define CS_WORD_ZERO 12'h000
`define CS_WORD_ONE 12'h001
`define CS_LSB_POS 0
`define CS_DEFAULT_SLOT 4'h0
`define CS_DEFAULT_COUNTER_LOC 12'h7E8
`endif

/* rtl/cycle_steal_pkg.sv */
// Types shared by the cycle-stealing block transfer controller
// Assumes the defines header is compiled alongside
package cycle_steal_pkg;
	typedef enum logic [2:0]
	{
		st_idle = 3'b000,
		st_request = 3'b001,
		st_count = 3'b010,
		st_address = 3'b011,
		st_data = 3'b100,
		st_exit = 3'b101
	} phase_type;

	typedef struct packed
	{
		logic [11:0] address;
		logic drive_address;
		logic to_memory;
		logic stall;
		logic force_one;
	} bus_drive_type;
endpackage

/* rtl/priority_check.sv */
// Priority test over the shared break request lines
// Assumes line 0 ranks highest and line 11 lowest
`timescale 1ns/10ps
`include "cycle_steal_defines.svh"
module priority_check
#(
	parameter int lines = `CS_PRIO_LINES
)
(
	input wire logic [lines-1:0] request_lines,
	input wire logic [3:0] slot,
	output logic granted
);
	always_comb
	begin
		granted = request_lines[slot];
		for (int i = 0; i < lines; i++)
		begin
			if (i < int'(slot) && request_lines[i])
			begin
				granted = 1'b0;
			end
		end
	end
endmodule

/* rtl/cycle_steal_block_transfer.sv */
// Device-side cycle-stealing block transfer controller
// Assumes synchronous inputs; memory cycles end on cycle_done pulses
//
// Function
// - Counter preloaded negated, overflows at zero
// - Twelve requesters each own priority line
// - Line 0 highest, line 11 lowest
// - Proceed only without higher pending request
// - Words move between data and buffer
// - Single-cycle mode steals one cycle per word
// - Three-cycle mode: count, address, data cycles
// - Single-cycle mode: both counters increment together before word
// - Finish current word before clearing enable (system_clear clears it at once, mid-word)
// - Priority test before driving address lines
// - Stall after win, drive direction with address
// - Release stall at cycle end, repeat or exit
// - Exit sets block completion flag
// - Enable raises request, win starts count cycle
// - Count cycle forces address bit 11 zero
// - Force one on data bit 11 for increment
// - Retest priority; address cycle forces bit 11 one
// - Incremented address latched into break address
// - Priority test again before data cycle
// - Without overflow, repeat three cycles
// - Overflow sets device flag, begins exit
// - Completion flag drives active-low interrupt line
`timescale 1ns/10ps
`include "cycle_steal_defines.svh"
module cycle_steal_block_transfer
#(
	parameter int width = `CS_WORD_WIDTH,
	parameter int lines = `CS_PRIO_LINES,
	parameter logic [3:0] slot = `CS_DEFAULT_SLOT,
	parameter logic [11:0] counter_loc = `CS_DEFAULT_COUNTER_LOC
)
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic system_clear,
	input wire logic three_cycle_mode,
	input wire logic load_length,
	input wire logic load_address,
	input wire logic [width-1:0] load_value,
	input wire logic io_transfer_instruction,
	input wire logic direction_to_memory,
	input wire logic clear_flag,
	input wire logic [lines-1:0] request_lines_in,
	input wire logic cycle_done,
	input wire logic [width-1:0] memory_buffer_register,
	input wire logic [width-1:0] device_word_in,
	output logic [lines-1:0] request_lines_out,
	output cycle_steal_pkg::bus_drive_type bus_drive,
	output logic [width-1:0] memory_address_lines,
	output logic [width-1:0] data_out,
	output logic data_out_enable,
	output logic [width-1:0] device_word_out,
	output logic device_word_valid,
	output logic [width-1:0] transfer_length_counter,
	output logic [width-1:0] next_address_counter,
	output logic enabled,
	output logic done_flag,
	output logic interrupt_request_n
);
	typedef struct packed
	{
		cycle_steal_pkg::phase_type phase;
		logic enable;
		logic to_memory;
		logic overflow;
		logic flag;
		logic [11:0] length;
		logic [11:0] address;
		logic [11:0] break_address;
		logic [11:0] word_out;
		logic word_valid;
		logic hold;
	} state_type;

	state_type state;
	state_type next_state;
	logic granted;
	logic [lines-1:0] all_requests;

	function automatic logic [11:0] bump(input logic [11:0] value);
		bump = value + `CS_WORD_ONE;
	endfunction

	function automatic logic [11:0] force_lsb(input logic [11:0] value,
		input logic bit_value);
		force_lsb = value;
		force_lsb[`CS_LSB_POS] = bit_value;
	endfunction

	wire logic requesting = state.enable &&
		state.phase != cycle_steal_pkg::st_idle &&
		state.phase != cycle_steal_pkg::st_exit;

	always_comb
	begin
		request_lines_out = '0;
		request_lines_out[slot] = requesting;
	end

	assign all_requests = request_lines_in | request_lines_out;

	priority_check #(.lines(lines)) arbiter
	(
		.request_lines(all_requests),
		.slot(slot),
		.granted(granted)
	);

	always_comb
	begin
		next_state = state;
		next_state.word_valid = 1'b0;
		if (clear_flag)
		begin
			next_state.flag = 1'b0;
		end
		if (load_length)
		begin
			next_state.length = load_value;
		end
		if (load_address)
		begin
			next_state.address = load_value;
		end
		case (state.phase)
			cycle_steal_pkg::st_idle:
			begin
				if (io_transfer_instruction)
				begin
					next_state.enable = 1'b1;
					next_state.to_memory = direction_to_memory;
					next_state.overflow = 1'b0;
					next_state.hold = 1'b0;
					next_state.phase = cycle_steal_pkg::st_request;
				end
			end
			cycle_steal_pkg::st_request:
			begin
				if (granted)
				begin
					if (three_cycle_mode)
					begin
						next_state.phase = cycle_steal_pkg::st_count;
					end
					else
					begin
						next_state.length = bump(state.length);
						next_state.address = bump(state.address);
						next_state.break_address = bump(state.address);
						next_state.overflow = bump(state.length) ==
							`CS_WORD_ZERO;
						next_state.phase = cycle_steal_pkg::st_data;
					end
				end
			end
			cycle_steal_pkg::st_count:
			begin
				if (cycle_done)
				begin
					next_state.overflow = memory_buffer_register ==
						`CS_WORD_ZERO;
					next_state.phase = cycle_steal_pkg::st_address;
					next_state.hold = !granted;
				end
			end
			cycle_steal_pkg::st_address:
			begin
				if (state.hold)
				begin
					next_state.hold = !granted;
				end
				else if (cycle_done)
				begin
					next_state.break_address = memory_buffer_register;
					next_state.phase = cycle_steal_pkg::st_data;
					next_state.hold = !granted;
				end
			end
			cycle_steal_pkg::st_data:
			begin
				if (state.hold)
				begin
					next_state.hold = !granted;
				end
				else if (cycle_done)
				begin
					if (!state.to_memory)
					begin
						next_state.word_out = memory_buffer_register;
						next_state.word_valid = 1'b1;
					end
					if (state.overflow)
					begin
						next_state.enable = 1'b0;
						next_state.phase = cycle_steal_pkg::st_exit;
					end
					else
					begin
						next_state.phase = cycle_steal_pkg::st_request;
					end
				end
			end
			cycle_steal_pkg::st_exit:
			begin
				next_state.flag = 1'b1;
				next_state.phase = cycle_steal_pkg::st_idle;
			end
			default:
			begin
				next_state.phase = cycle_steal_pkg::st_idle;
			end
		endcase
		if (system_clear)
		begin
			next_state.enable = 1'b0;
			next_state.hold = 1'b0;
			next_state.flag = 1'b0;
			next_state.phase = cycle_steal_pkg::st_idle;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	// A lost retest parks the phase with the bus released
	wire logic in_count = state.phase == cycle_steal_pkg::st_count;
	wire logic in_addr = state.phase == cycle_steal_pkg::st_address &&
		!state.hold;
	wire logic in_data = state.phase == cycle_steal_pkg::st_data &&
		!state.hold;
	wire logic on_bus = in_count || in_addr || in_data;

	always_comb
	begin
		bus_drive.stall = on_bus;
		bus_drive.drive_address = on_bus;
		bus_drive.to_memory = in_data && state.to_memory;
		bus_drive.force_one = in_count || in_addr;
		if (in_count)
		begin
			bus_drive.address = force_lsb(counter_loc, 1'b0);
		end
		else if (in_addr)
		begin
			bus_drive.address = force_lsb(counter_loc, 1'b1);
		end
		else if (in_data)
		begin
			bus_drive.address = state.break_address;
		end
		else
		begin
			bus_drive.address = '0;
		end
	end

	assign memory_address_lines = bus_drive.address;
	assign data_out = bus_drive.force_one ? `CS_WORD_ONE : device_word_in;
	assign data_out_enable = bus_drive.force_one ||
		(in_data && state.to_memory);
	assign device_word_out = state.word_out;
	assign device_word_valid = state.word_valid;
	assign transfer_length_counter = state.length;
	assign next_address_counter = state.address;
	assign enabled = state.enable;
	assign done_flag = state.flag;
	assign interrupt_request_n = !state.flag;

	a_stall_has_grant: assert property (
		@(posedge clock) disable iff (!rst_n)
		state.phase == cycle_steal_pkg::st_request && granted &&
		!system_clear |=> bus_drive.stall)
		else $error("stall missing after win");
	a_no_win_no_bus: assert property (
		@(posedge clock) disable iff (!rst_n)
		state.phase == cycle_steal_pkg::st_request && !granted &&
		!system_clear |=> !bus_drive.drive_address)
		else $error("address driven without win");
	a_higher_blocks: assert property (
		@(posedge clock) disable iff (!rst_n)
		slot != 4'h0 && request_lines_in[0] |-> !granted)
		else $error("lower line granted over line 0");
	a_count_even: assert property (
		@(posedge clock) disable iff (!rst_n)
		in_count |-> !memory_address_lines[0])
		else $error("count address not even");
	a_addr_odd: assert property (
		@(posedge clock) disable iff (!rst_n)
		in_addr |-> memory_address_lines[0] && data_out == 12'h001)
		else $error("address cycle bad");
	a_single_steps: assert property (
		@(posedge clock) disable iff (!rst_n)
		state.phase == cycle_steal_pkg::st_request && granted &&
		!three_cycle_mode && !system_clear && !load_length |=>
		transfer_length_counter == $past(transfer_length_counter) + 12'h001)
		else $error("length not stepped");
	a_three_order: assert property (
		@(posedge clock) disable iff (!rst_n)
		in_count && cycle_done && !system_clear |=>
		state.phase == cycle_steal_pkg::st_address)
		else $error("address cycle not after count");
	a_break_latch: assert property (
		@(posedge clock) disable iff (!rst_n)
		in_addr && cycle_done && !system_clear |=>
		state.break_address == $past(memory_buffer_register))
		else $error("break address not latched");
	a_overflow_exit: assert property (
		@(posedge clock) disable iff (!rst_n)
		in_data && cycle_done && state.overflow && !system_clear
		|=> !enabled ##1 done_flag && !interrupt_request_n)
		else $error("exit sequence wrong");
	a_clear_drops: assert property (
		@(posedge clock) disable iff (!rst_n)
		system_clear |=> request_lines_out == '0)
		else $error("request held after clear");
	a_retest_address: assert property (
		@(posedge clock) disable iff (!rst_n)
		in_count && cycle_done && !granted && !system_clear |=>
		!bus_drive.stall && !bus_drive.drive_address)
		else $error("address cycle began without priority");
	a_retest_data: assert property (
		@(posedge clock) disable iff (!rst_n)
		in_addr && cycle_done && !granted && !system_clear |=>
		!bus_drive.stall && !bus_drive.drive_address)
		else $error("data cycle began without priority");

	c_single_word: cover property (@(posedge clock) disable iff (!rst_n)
		in_data && !three_cycle_mode && cycle_done);
	c_three_word: cover property (@(posedge clock) disable iff (!rst_n)
		in_addr ##1 in_data);
	c_block_done: cover property (@(posedge clock) disable iff (!rst_n)
		$rose(done_flag));
	c_lost_priority: cover property (@(posedge clock) disable iff (!rst_n)
		requesting && !granted);
	c_retest_lost: cover property (@(posedge clock) disable iff (!rst_n)
		in_count && cycle_done && !granted);
endmodule

/* bench/backplane_memory.sv */
// Processor and main memory model answering stolen cycles
// Assumes bus_drive settles after each rising edge of clock
`timescale 1ns/10ps
module backplane_memory
(
	input wire logic clock,
	input wire logic [3:0] wait_cycles,
	input wire cycle_steal_pkg::bus_drive_type bus_drive,
	input wire logic [11:0] memory_address_lines,
	input wire logic [11:0] data_out,
	output logic cycle_done,
	output logic [11:0] memory_buffer_register
);
	logic [11:0] words [0:4095];
	logic [3:0] waited = 4'h0;
	logic [11:0] sum;
	initial
	begin
		cycle_done = 1'b0;
		memory_buffer_register = 12'h000;
	end
	// Buffer contents are only valid with the cycle end pulse
	always @(negedge clock)
	begin
		cycle_done <= 1'b0;
		memory_buffer_register <= ~memory_buffer_register;
		if (bus_drive.stall && bus_drive.drive_address && !cycle_done)
		begin
			if (waited < wait_cycles)
				waited <= waited + 4'h1;
			else
			begin
				waited <= 4'h0;
				cycle_done <= 1'b1;
				sum = words[memory_address_lines] + data_out;
				if (bus_drive.force_one)
				begin
					words[memory_address_lines] <= sum;
					memory_buffer_register <= sum;
				end
				else if (bus_drive.to_memory)
					words[memory_address_lines] <= data_out;
				else
					memory_buffer_register <= words[memory_address_lines];
			end
		end
	end
endmodule

/* bench/cycle_steal_block_transfer_tb_top.sv */
// Testbench for the cycle-stealing block transfer controller
// Assumes the backplane_memory model as the processor side
`timescale 1ns/10ps
module cycle_steal_block_transfer_tb_top;
	localparam logic [11:0] even_loc = 12'h7E8;
	localparam logic [11:0] odd_loc = 12'h7E9;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic system_clear = 1'b0;
	logic three_cycle_mode = 1'b0;
	logic load_length = 1'b0;
	logic load_address = 1'b0;
	logic [11:0] load_value = 12'h000;
	logic io_transfer_instruction = 1'b0;
	logic direction_to_memory = 1'b0;
	logic clear_flag = 1'b0;
	logic [11:0] request_lines_in = 12'h000;
	logic [11:0] device_word_in = 12'h5A3;
	logic [3:0] wait_cycles = 4'h3;
	logic cycle_done, data_out_enable, device_word_valid;
	logic enabled, done_flag, interrupt_request_n;
	logic [11:0] memory_buffer_register, request_lines_out, data_out;
	logic [11:0] memory_address_lines, device_word_out, last_read;
	logic [11:0] transfer_length_counter, next_address_counter;
	cycle_steal_pkg::bus_drive_type bus_drive;
	int failures = 0;
	int n_compared = 0;
	int stolen = 0;
	int i;
	always #25 clock = ~clock;
	always @(posedge clock)
	begin
		if (cycle_done === 1'b1)
			stolen <= stolen + 1;
		if (device_word_valid === 1'b1)
			last_read <= device_word_out;
	end
	cycle_steal_block_transfer #(.slot(4'h3)) dut
	(
		.clock(clock), .rst_n(rst_n), .system_clear(system_clear),
		.three_cycle_mode(three_cycle_mode), .load_length(load_length),
		.load_address(load_address), .load_value(load_value),
		.io_transfer_instruction(io_transfer_instruction),
		.direction_to_memory(direction_to_memory), .clear_flag(clear_flag),
		.request_lines_in(request_lines_in), .cycle_done(cycle_done),
		.memory_buffer_register(memory_buffer_register),
		.device_word_in(device_word_in),
		.request_lines_out(request_lines_out), .bus_drive(bus_drive),
		.memory_address_lines(memory_address_lines), .data_out(data_out),
		.data_out_enable(data_out_enable), .device_word_out(device_word_out),
		.device_word_valid(device_word_valid),
		.transfer_length_counter(transfer_length_counter),
		.next_address_counter(next_address_counter), .enabled(enabled),
		.done_flag(done_flag), .interrupt_request_n(interrupt_request_n)
	);
	backplane_memory mem
	(
		.clock(clock), .wait_cycles(wait_cycles), .bus_drive(bus_drive),
		.memory_address_lines(memory_address_lines), .data_out(data_out),
		.cycle_done(cycle_done),
		.memory_buffer_register(memory_buffer_register)
	);
	task automatic check(input string what, input logic [11:0] seen,
		input logic [11:0] expected);
		n_compared++;
		if (seen !== expected)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, expected, seen);
		end
	endtask
	task automatic load(input logic [11:0] length_neg, input logic [11:0] addr);
		@(negedge clock);
		load_length = 1'b1;
		load_value = length_neg;
		@(negedge clock);
		load_length = 1'b0;
		load_address = 1'b1;
		load_value = addr;
		@(negedge clock);
		load_address = 1'b0;
	endtask
	task automatic start(input logic mode, input logic dir);
		@(negedge clock);
		three_cycle_mode = mode;
		direction_to_memory = dir;
		io_transfer_instruction = 1'b1;
		stolen = 0;
		@(negedge clock);
		io_transfer_instruction = 1'b0;
	endtask
	task automatic finish_block;
		for (i = 0; i < 400 && done_flag !== 1'b1; i++)
			@(negedge clock);
		check("done_flag", {11'h000, done_flag}, 12'h001);
		check("irq_n", {11'h000, interrupt_request_n}, 12'h000);
		check("enabled", {11'h000, enabled}, 12'h000);
		@(negedge clock);
		clear_flag = 1'b1;
		@(negedge clock);
		clear_flag = 1'b0;
		@(negedge clock);
		check("irq_n clear", {11'h000, interrupt_request_n}, 12'h001);
	endtask
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#(50 * 4000);
		failures++;
		close_out();
	end
	initial
	begin
		repeat (6) @(negedge clock);
		rst_n = 1'b1;
		// Single-cycle write of three words, slow memory
		load(12'hFFD, 12'h0FF);
		start(1'b0, 1'b1);
		finish_block();
		for (i = 0; i < 3; i++)
			check("written", mem.words[12'h100 + i], 12'h5A3);
		check("stolen single", 12'(stolen), 12'h003);
		check("length", transfer_length_counter, 12'h000);
		check("address", next_address_counter, 12'h102);
		$display("test single write done");
		// Higher line blocks, lower line does not
		request_lines_in = 12'h003;
		load(12'hFFF, 12'h2FF);
		start(1'b0, 1'b1);
		repeat (20) @(negedge clock);
		check("request line", request_lines_out, 12'h008);
		check("stall blocked", {11'h000, bus_drive.stall}, 12'h000);
		check("address blocked", memory_address_lines, 12'h000);
		request_lines_in = 12'h010;
		finish_block();
		check("after win", mem.words[12'h300], 12'h5A3);
		request_lines_in = 12'h000;
		$display("test priority done");
		// Three-cycle read of two words
		wait_cycles = 4'h0;
		mem.words[even_loc] = 12'hFFE;
		mem.words[odd_loc] = 12'h3FF;
		mem.words[12'h400] = 12'h123;
		mem.words[12'h401] = 12'h456;
		start(1'b1, 1'b0);
		finish_block();
		check("stolen three", 12'(stolen), 12'h006);
		check("count word", mem.words[even_loc], 12'h000);
		check("address word", mem.words[odd_loc], 12'h401);
		check("read word", last_read, 12'h456);
		$display("test three-cycle read done");
		// Three-cycle write, line 0 cuts in during the count cycle
		wait_cycles = 4'h2;
		mem.words[even_loc] = 12'hFFF;
		mem.words[odd_loc] = 12'h5FF;
		start(1'b1, 1'b1);
		for (i = 0; i < 20 && bus_drive.stall !== 1'b1; i++)
			@(negedge clock);
		request_lines_in = 12'h001;
		repeat (10) @(negedge clock);
		check("retest stall", {11'h000, bus_drive.stall}, 12'h000);
		check("retest address", memory_address_lines, 12'h000);
		check("retest drive", {11'h000, data_out_enable}, 12'h000);
		request_lines_in = 12'h000;
		finish_block();
		check("retest word", mem.words[12'h600], 12'h5A3);
		check("retest count", mem.words[even_loc], 12'h000);
		check("retest address word", mem.words[odd_loc], 12'h600);
		$display("test priority retest done");
		// System clear in mid-block
		wait_cycles = 4'h2;
		load(12'hF00, 12'h4FF);
		start(1'b0, 1'b1);
		repeat (12) @(negedge clock);
		system_clear = 1'b1;
		@(negedge clock);
		system_clear = 1'b0;
		check("abort enable", {11'h000, enabled}, 12'h000);
		check("abort request", request_lines_out, 12'h000);
		check("abort stall", {11'h000, bus_drive.stall}, 12'h000);
		check("abort flag", {11'h000, done_flag}, 12'h000);
		$display("test system clear done");
		close_out();
	end
endmodule
